// *** vdpo_pkg.sv ***
// Purpose: Shared constants for the picture output register bank.
// Assumes: 8-bit registers reached over the two-wire serial control port.
// Notes: Offsets are subaddresses; masks clear reserved bits on write.
package vdpo_pkg;

  // Register subaddresses
  localparam logic [7:0] VDPO_OFF_LUMA1 = 8'h07;
  localparam logic [7:0] VDPO_OFF_LUMA2 = 8'h08;
  localparam logic [7:0] VDPO_OFF_BRIGHT = 8'h09;
  localparam logic [7:0] VDPO_OFF_SAT = 8'h0a;
  localparam logic [7:0] VDPO_OFF_HUE = 8'h0b;
  localparam logic [7:0] VDPO_OFF_CONTRAST = 8'h0c;
  localparam logic [7:0] VDPO_OFF_OUTFMT = 8'h0d;
  localparam logic [7:0] VDPO_OFF_LUMA3 = 8'h0e;
  localparam logic [7:0] VDPO_OFF_PINS = 8'h0f;
  localparam logic [7:0] VDPO_OFF_AV_HI = 8'h11;
  localparam logic [7:0] VDPO_OFF_AV_LO = 8'h12;

  // Values after reset
  localparam logic [7:0] VDPO_RST_LUMA1 = 8'h60;
  localparam logic [7:0] VDPO_RST_LUMA2 = 8'h00;
  localparam logic [7:0] VDPO_RST_BRIGHT = 8'h80;
  localparam logic [7:0] VDPO_RST_SAT = 8'h80;
  localparam logic [7:0] VDPO_RST_HUE = 8'h00;
  localparam logic [7:0] VDPO_RST_CONTRAST = 8'h80;
  localparam logic [7:0] VDPO_RST_OUTFMT = 8'h47;
  localparam logic [7:0] VDPO_RST_LUMA3 = 8'h00;
  localparam logic [7:0] VDPO_RST_PINS = 8'h08;
  localparam logic [7:0] VDPO_RST_AV_HI = 8'h00;
  localparam logic [1:0] VDPO_RST_AV_LO = 2'h0;

  // Writable bit masks (reserved bits store and read zero)
  localparam logic [7:0] VDPO_MSK_LUMA2 = 8'h4f;
  localparam logic [7:0] VDPO_MSK_OUTFMT = 8'h7f;
  localparam logic [7:0] VDPO_MSK_LUMA3 = 8'h60;
  localparam logic [7:0] VDPO_MSK_PINS = 8'h5e;

  // Picture constants
  localparam logic [7:0] VDPO_DUMMY_HDR = 8'h40;
  localparam logic [7:0] VDPO_CONTRAST_MAX = 8'hcf;
  localparam logic [7:0] VDPO_Y_MIN_601 = 8'h10;
  localparam logic [7:0] VDPO_Y_MAX_601 = 8'heb;
  localparam logic [7:0] VDPO_C_MAX_601 = 8'hf0;
  localparam logic [7:0] VDPO_EXT_MIN = 8'h01;
  localparam logic [7:0] VDPO_EXT_MAX = 8'hfe;
  localparam logic [2:0] VDPO_FMT_EMBEDDED = 3'h7;
  localparam logic [2:0] VDPO_FMT_DISCRETE = 3'h0;
  localparam logic signed [17:0] VDPO_BLACK_NOM_Q8 = 18'sh01000;
  localparam logic signed [17:0] VDPO_MID_CODE = 18'sh00080;
  localparam logic signed [17:0] VDPO_BLACK_SLOPE = 18'sh000db;

  // Serial port slave address, value is arbitrary
  localparam logic [6:0] VDPO_DEV_ADDR = 7'h2a;

  // Serial port states
  typedef enum logic [3:0] {
    VDPO_ST_IDLE = 4'h0,
    VDPO_ST_ADDR = 4'h1,
    VDPO_ST_ACK_ADDR = 4'h2,
    VDPO_ST_SUB = 4'h3,
    VDPO_ST_ACK_SUB = 4'h4,
    VDPO_ST_WDATA = 4'h5,
    VDPO_ST_ACK_W = 4'h6,
    VDPO_ST_RDATA = 4'h7,
    VDPO_ST_RACK = 4'h8
  } vdpo_i2c_st_t;

endpackage: vdpo_pkg

// *** vdpo_regs.sv ***
// Purpose: Picture output control registers behind a two-wire serial port.
// Assumes: SCL and SDA arrive from pins; status inputs share CLK.
// Notes: All outputs are registered; CE low freezes every flip-flop.
// Functional notes
// RQ1 - Double-rate luma bit gives 2x whole frame
// RQ2 - Bypass bit gives 2x luma in vertical blanking
// RQ3 - Raw header disable forces dummy 40h headers
// RQ4 - Pedestal-absent clear means 7.5 IRE setup
// RQ5 - Luma delay signed four bits, -8..+7
// RQ6 - Filter select: comb when clear, trap set
// RQ7 - Sharpness codes give peaking 0, .5, 1, 2
// RQ8 - AGC detect auto, forced off, forced on
// RQ9 - Black level from brightness and contrast
// RQ10 - Chroma gain is saturation over 128
// RQ11 - Signed hue rotation, none for SECAM
// RQ12 - Contrast gain capped at code 207
// RQ13 - Code range picks 601 or extended limits
// RQ14 - Chroma offset binary or two's complement
// RQ15 - Datapath bypass selects output source
// RQ16 - Output format discrete or embedded sync
// RQ17 - Trap select plus wide bit pick notch
// RQ18 - Pin 23 field, lock or genlock select
// RQ19 - Pin 24 vsync, PAL line or lock select
// RQ20 - Pin 27 interrupt, level or blank flag
// RQ21 - Software writes zero to pin bit 0
// RQ22 - Software writes start upper before lower
// RQ23 - Upper start bits held until lower write
// RQ24 - Start offset is signed ten bits
// RQ25 - Fields read back, reset to defaults
`timescale 1ns/1ps
module vdpo_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic VBLANK_ACTIVE,
  input wire logic SECAM_SOURCE,
  input wire logic WIDE_CHROMA_FILTER_BIT,
  input wire logic FIELD_INDICATOR,
  input wire logic GENLOCK_SERIAL_OUT,
  input wire logic VSYNC_IN,
  input wire logic PAL_LINE_INDICATOR,
  input wire logic VERT_LOCKED,
  input wire logic HORIZ_LOCKED,
  input wire logic INTERRUPT_REQUEST_IN,
  input wire logic GENERAL_PURPOSE_LEVEL,
  input wire logic VERTICAL_BLANK_FLAG,
  input wire logic VERTICAL_BLANK_FLAG_GENERAL_PURPOSE_LEVEL_SELECT,
  output logic LUMA_2X_NOW,
  output logic RAW_HEADER_DUMMY,
  output logic PEDESTAL_PRESENT,
  output logic [3:0] LUMA_DELAY,
  output logic LUMA_TRAP_SELECT,
  output logic [2:0] PEAK_GAIN_HALVES,
  output logic CP_DETECT_AUTO,
  output logic CP_DETECT_FORCE_ON,
  output logic [17:0] BLACK_LEVEL_Q8,
  output logic [7:0] CHROMA_GAIN,
  output logic [7:0] HUE_ROTATION,
  output logic [7:0] LUMA_GAIN,
  output logic [7:0] Y_MIN,
  output logic [7:0] Y_MAX,
  output logic [7:0] C_MIN,
  output logic [7:0] C_MAX,
  output logic CHROMA_TWOS_COMP,
  output logic [1:0] DATAPATH_SOURCE,
  output logic EMBEDDED_SYNC,
  output logic DISCRETE_SYNC,
  output logic [2:0] NOTCH_SELECT,
  output logic PIN23_OUT,
  output logic PIN24_OUT,
  output logic PIN27_OUT,
  output logic [9:0] ACTIVE_START_OFFSET
);

  // Whole block state in one record
  typedef struct packed {
    logic scl_m; // Pin synchroniser, first stage
    logic scl_s; // Pin synchroniser, second stage
    logic scl_p; // Previous synchronised clock
    logic sda_m;
    logic sda_s;
    logic sda_p;
    vdpo_pkg::vdpo_i2c_st_t st; // Serial port state
    logic [3:0] cnt; // Bits seen in current byte
    logic [7:0] sh; // Shift register
    logic rw; // Read transfer flag
    logic [7:0] sub; // Register pointer
    logic sda_oe; // Pull SDA low
    logic sda_o; // Driven level, always low
    logic [7:0] r07;
    logic [7:0] r08;
    logic [7:0] r09;
    logic [7:0] r0a;
    logic [7:0] r0b;
    logic [7:0] r0c;
    logic [7:0] r0d;
    logic [7:0] r0e;
    logic [7:0] r0f;
    logic [7:0] r11; // Held upper start bits
    logic [1:0] r12; // Lower start bits
    logic [9:0] av_start; // Applied start offset
    logic luma2x;
    logic [2:0] peak;
    logic cp_auto;
    logic cp_on;
    logic [17:0] black;
    logic [7:0] hue;
    logic [7:0] lgain;
    logic [7:0] ymin;
    logic [7:0] ymax;
    logic [7:0] cmin;
    logic [7:0] cmax;
    logic emb;
    logic disc;
    logic [2:0] notch;
    logic pin23;
    logic pin24;
    logic pin27;
  } vdpo_state_t;

  vdpo_state_t s_q; // Registered state
  vdpo_state_t s_d; // Next state
  logic scl_rise; // Clock edges on the serial port
  logic scl_fall;
  logic start_c; // Start condition seen
  logic stop_c; // Stop condition seen
  logic wr_en; // One register write this cycle
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ceff; // Contrast limited to the usable top
  logic signed [17:0] bdiff; // Brightness minus mid code
  logic signed [17:0] cdiff; // Mid code minus contrast

  // Read multiplexer, unmapped addresses answer zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a, input vdpo_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a) // RQ25
      vdpo_pkg::VDPO_OFF_LUMA1: v = s.r07;
      vdpo_pkg::VDPO_OFF_LUMA2: v = s.r08;
      vdpo_pkg::VDPO_OFF_BRIGHT: v = s.r09;
      vdpo_pkg::VDPO_OFF_SAT: v = s.r0a;
      vdpo_pkg::VDPO_OFF_HUE: v = s.r0b;
      vdpo_pkg::VDPO_OFF_CONTRAST: v = s.r0c;
      vdpo_pkg::VDPO_OFF_OUTFMT: v = s.r0d;
      vdpo_pkg::VDPO_OFF_LUMA3: v = s.r0e;
      vdpo_pkg::VDPO_OFF_PINS: v = s.r0f;
      vdpo_pkg::VDPO_OFF_AV_HI: v = s.r11;
      vdpo_pkg::VDPO_OFF_AV_LO: v = {6'h00, s.r12};
      default: v = 8'h00;
    endcase
    return v;
  endfunction: rd_reg

  // Bus events from synchronised pins only
  always_comb begin
    scl_rise = s_q.scl_s & ~s_q.scl_p;
    scl_fall = ~s_q.scl_s & s_q.scl_p;
    start_c = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
    stop_c = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
    wr_en = CE & ~start_c & ~stop_c & scl_fall & (s_q.st == vdpo_pkg::VDPO_ST_WDATA) &
            (s_q.cnt == 4'h8);
    wr_addr = s_q.sub;
    wr_data = s_q.sh;
  end

  // Black level arithmetic, value times 256
  always_comb begin
    ceff = (s_q.r0c > vdpo_pkg::VDPO_CONTRAST_MAX) ? vdpo_pkg::VDPO_CONTRAST_MAX
                                                    : s_q.r0c; // RQ12
    bdiff = $signed({10'h000, s_q.r09}) - vdpo_pkg::VDPO_MID_CODE;
    cdiff = vdpo_pkg::VDPO_MID_CODE - $signed({10'h000, ceff});
  end

  // Next state
  always_comb begin
    s_d = s_q;
    if (CE) begin
      // Two flip-flops per pin before any logic
      s_d.scl_m = SCL_I;
      s_d.scl_s = s_q.scl_m;
      s_d.scl_p = s_q.scl_s;
      s_d.sda_m = SDA_I;
      s_d.sda_s = s_q.sda_m;
      s_d.sda_p = s_q.sda_s;
      // Serial port sequencing
      if (stop_c) begin
        s_d.st = vdpo_pkg::VDPO_ST_IDLE;
        s_d.sda_oe = 1'b0;
      end else if (start_c) begin
        // Start or repeated start keeps the pointer
        s_d.st = vdpo_pkg::VDPO_ST_ADDR;
        s_d.cnt = 4'h0;
        s_d.sda_oe = 1'b0;
      end else if (scl_rise) begin
        case (s_q.st)
          vdpo_pkg::VDPO_ST_ADDR, vdpo_pkg::VDPO_ST_SUB, vdpo_pkg::VDPO_ST_WDATA: begin
            s_d.sh = {s_q.sh[6:0], s_q.sda_s};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          vdpo_pkg::VDPO_ST_RDATA: begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
          vdpo_pkg::VDPO_ST_RACK: begin
            // Master not acknowledging ends the read
            if (s_q.sda_s) begin
              s_d.st = vdpo_pkg::VDPO_ST_IDLE;
            end
          end
          default: begin
            s_d.st = s_q.st;
          end
        endcase
      end else if (scl_fall) begin
        case (s_q.st)
          vdpo_pkg::VDPO_ST_ADDR: begin
            if (s_q.cnt == 4'h8) begin
              // Acknowledge only our own address
              if (s_q.sh[7:1] == vdpo_pkg::VDPO_DEV_ADDR) begin
                s_d.rw = s_q.sh[0];
                s_d.sda_oe = 1'b1;
                s_d.st = vdpo_pkg::VDPO_ST_ACK_ADDR;
              end else begin
                s_d.st = vdpo_pkg::VDPO_ST_IDLE;
              end
            end
          end
          vdpo_pkg::VDPO_ST_ACK_ADDR: begin
            s_d.cnt = 4'h0;
            if (s_q.rw) begin
              // Present first read byte, MSB first
              s_d.sh = rd_reg(s_q.sub, s_q);
              s_d.sda_oe = ~s_d.sh[7];
              s_d.st = vdpo_pkg::VDPO_ST_RDATA;
            end else begin
              s_d.sda_oe = 1'b0;
              s_d.st = vdpo_pkg::VDPO_ST_SUB;
            end
          end
          vdpo_pkg::VDPO_ST_SUB: begin
            if (s_q.cnt == 4'h8) begin
              s_d.sub = s_q.sh;
              s_d.sda_oe = 1'b1;
              s_d.st = vdpo_pkg::VDPO_ST_ACK_SUB;
            end
          end
          vdpo_pkg::VDPO_ST_ACK_SUB, vdpo_pkg::VDPO_ST_ACK_W: begin
            // Release after acknowledge, pointer steps after data
            if (s_q.st == vdpo_pkg::VDPO_ST_ACK_W) begin
              s_d.sub = s_q.sub + 8'h01;
            end
            s_d.sda_oe = 1'b0;
            s_d.cnt = 4'h0;
            s_d.st = vdpo_pkg::VDPO_ST_WDATA;
          end
          vdpo_pkg::VDPO_ST_WDATA: begin
            if (s_q.cnt == 4'h8) begin
              s_d.sda_oe = 1'b1;
              s_d.st = vdpo_pkg::VDPO_ST_ACK_W;
            end
          end
          vdpo_pkg::VDPO_ST_RDATA: begin
            if (s_q.cnt == 4'h8) begin
              s_d.sda_oe = 1'b0;
              s_d.st = vdpo_pkg::VDPO_ST_RACK;
            end else begin
              s_d.sh = {s_q.sh[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
          vdpo_pkg::VDPO_ST_RACK: begin
            // Acknowledged: stream the next register
            s_d.sub = s_q.sub + 8'h01;
            s_d.sh = rd_reg(s_q.sub + 8'h01, s_q);
            s_d.sda_oe = ~s_d.sh[7];
            s_d.cnt = 4'h0;
            s_d.st = vdpo_pkg::VDPO_ST_RDATA;
          end
          default: begin
            s_d.sda_oe = 1'b0;
          end
        endcase
      end
      // Register writes, reserved bits masked
      if (wr_en) begin
        case (wr_addr)
          vdpo_pkg::VDPO_OFF_LUMA1: s_d.r07 = wr_data;
          vdpo_pkg::VDPO_OFF_LUMA2: s_d.r08 = wr_data & vdpo_pkg::VDPO_MSK_LUMA2;
          vdpo_pkg::VDPO_OFF_BRIGHT: s_d.r09 = wr_data;
          vdpo_pkg::VDPO_OFF_SAT: s_d.r0a = wr_data;
          vdpo_pkg::VDPO_OFF_HUE: s_d.r0b = wr_data;
          vdpo_pkg::VDPO_OFF_CONTRAST: s_d.r0c = wr_data;
          vdpo_pkg::VDPO_OFF_OUTFMT: s_d.r0d = wr_data & vdpo_pkg::VDPO_MSK_OUTFMT;
          vdpo_pkg::VDPO_OFF_LUMA3: s_d.r0e = wr_data & vdpo_pkg::VDPO_MSK_LUMA3;
          vdpo_pkg::VDPO_OFF_PINS: s_d.r0f = wr_data & vdpo_pkg::VDPO_MSK_PINS; // RQ21
          vdpo_pkg::VDPO_OFF_AV_HI: s_d.r11 = wr_data; // RQ23 RQ22
          vdpo_pkg::VDPO_OFF_AV_LO: begin
            // Lower write applies the held upper bits
            s_d.r12 = wr_data[1:0];
            s_d.av_start = {s_q.r11, wr_data[1:0]}; // RQ23 RQ24
          end
          default: begin
            s_d.sub = s_q.sub;
          end
        endcase
      end
      // Luma sample rate, whole frame wins over blanking bypass
      s_d.luma2x = s_q.r07[7] | (s_q.r07[4] & VBLANK_ACTIVE); // RQ1 RQ2
      // Peaking gain in half steps
      case (s_q.r08[3:2]) // RQ7
        2'h0: s_d.peak = 3'h0;
        2'h1: s_d.peak = 3'h1;
        2'h2: s_d.peak = 3'h2;
        default: s_d.peak = 3'h4;
      endcase
      // Copy-protection pulse detection mode
      s_d.cp_auto = ~s_q.r08[1]; // RQ8
      s_d.cp_on = (s_q.r08[1:0] == 2'h3); // RQ8
      s_d.black = 18'(vdpo_pkg::VDPO_BLACK_NOM_Q8 + (bdiff <<< 8) +
                      cdiff * vdpo_pkg::VDPO_BLACK_SLOPE); // RQ9
      s_d.hue = SECAM_SOURCE ? 8'h00 : s_q.r0b; // RQ11
      s_d.lgain = ceff; // RQ12
      // Output code limits
      if (s_q.r0d[6]) begin // RQ13
        s_d.ymin = vdpo_pkg::VDPO_EXT_MIN;
        s_d.ymax = vdpo_pkg::VDPO_EXT_MAX;
        s_d.cmin = vdpo_pkg::VDPO_EXT_MIN;
        s_d.cmax = vdpo_pkg::VDPO_EXT_MAX;
      end else begin
        s_d.ymin = vdpo_pkg::VDPO_Y_MIN_601;
        s_d.ymax = vdpo_pkg::VDPO_Y_MAX_601;
        s_d.cmin = vdpo_pkg::VDPO_Y_MIN_601;
        s_d.cmax = vdpo_pkg::VDPO_C_MAX_601;
      end
      s_d.emb = (s_q.r0d[2:0] == vdpo_pkg::VDPO_FMT_EMBEDDED); // RQ16
      s_d.disc = (s_q.r0d[2:0] == vdpo_pkg::VDPO_FMT_DISCRETE); // RQ16
      s_d.notch = {WIDE_CHROMA_FILTER_BIT, s_q.r0e[6:5]}; // RQ17
      // Shared pin routing
      s_d.pin23 = s_q.r0f[3] ? GENLOCK_SERIAL_OUT
                             : (s_q.r0f[6] ? VERT_LOCKED : FIELD_INDICATOR); // RQ18
      s_d.pin24 = s_q.r0f[2] ? (s_q.r0f[4] ? HORIZ_LOCKED : PAL_LINE_INDICATOR)
                             : VSYNC_IN; // RQ19
      s_d.pin27 = s_q.r0f[1] ? (VERTICAL_BLANK_FLAG_GENERAL_PURPOSE_LEVEL_SELECT ? VERTICAL_BLANK_FLAG : GENERAL_PURPOSE_LEVEL)
                             : INTERRUPT_REQUEST_IN; // RQ20
    end
  end

  // State register, constants under reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.scl_m <= 1'b1;
      s_q.scl_s <= 1'b1;
      s_q.scl_p <= 1'b1;
      s_q.sda_m <= 1'b1;
      s_q.sda_s <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.st <= vdpo_pkg::VDPO_ST_IDLE;
      s_q.r07 <= vdpo_pkg::VDPO_RST_LUMA1; // RQ25 RQ3 RQ4
      s_q.r08 <= vdpo_pkg::VDPO_RST_LUMA2;
      s_q.r09 <= vdpo_pkg::VDPO_RST_BRIGHT;
      s_q.r0a <= vdpo_pkg::VDPO_RST_SAT;
      s_q.r0b <= vdpo_pkg::VDPO_RST_HUE;
      s_q.r0c <= vdpo_pkg::VDPO_RST_CONTRAST;
      s_q.r0d <= vdpo_pkg::VDPO_RST_OUTFMT;
      s_q.r0e <= vdpo_pkg::VDPO_RST_LUMA3;
      s_q.r0f <= vdpo_pkg::VDPO_RST_PINS;
      s_q.r11 <= vdpo_pkg::VDPO_RST_AV_HI;
      s_q.r12 <= vdpo_pkg::VDPO_RST_AV_LO;
      s_q.cp_auto <= 1'b1;
      s_q.black <= vdpo_pkg::VDPO_BLACK_NOM_Q8;
      s_q.lgain <= vdpo_pkg::VDPO_RST_CONTRAST;
      s_q.ymin <= vdpo_pkg::VDPO_EXT_MIN;
      s_q.ymax <= vdpo_pkg::VDPO_EXT_MAX;
      s_q.cmin <= vdpo_pkg::VDPO_EXT_MIN;
      s_q.cmax <= vdpo_pkg::VDPO_EXT_MAX;
      s_q.emb <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign SDA_O = s_q.sda_o;
  assign SDA_OE = s_q.sda_oe;
  assign LUMA_2X_NOW = s_q.luma2x;
  assign RAW_HEADER_DUMMY = s_q.r07[5]; // RQ3
  assign PEDESTAL_PRESENT = ~s_q.r07[6]; // RQ4
  assign LUMA_DELAY = s_q.r07[3:0]; // RQ5
  assign LUMA_TRAP_SELECT = s_q.r08[6]; // RQ6
  assign PEAK_GAIN_HALVES = s_q.peak;
  assign CP_DETECT_AUTO = s_q.cp_auto;
  assign CP_DETECT_FORCE_ON = s_q.cp_on;
  assign BLACK_LEVEL_Q8 = s_q.black;
  assign CHROMA_GAIN = s_q.r0a; // RQ10
  assign HUE_ROTATION = s_q.hue;
  assign LUMA_GAIN = s_q.lgain;
  assign Y_MIN = s_q.ymin;
  assign Y_MAX = s_q.ymax;
  assign C_MIN = s_q.cmin;
  assign C_MAX = s_q.cmax;
  assign CHROMA_TWOS_COMP = s_q.r0d[5]; // RQ14
  assign DATAPATH_SOURCE = s_q.r0d[4:3]; // RQ15
  assign EMBEDDED_SYNC = s_q.emb;
  assign DISCRETE_SYNC = s_q.disc;
  assign NOTCH_SELECT = s_q.notch;
  assign PIN23_OUT = s_q.pin23;
  assign PIN24_OUT = s_q.pin24;
  assign PIN27_OUT = s_q.pin27;
  assign ACTIVE_START_OFFSET = s_q.av_start;

  // Checks on the block's own outputs
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_luma_whole_frame: assert property ( // RQ1
    CE && s_q.r07[7] |=> LUMA_2X_NOW) else $error("2x luma not held for frame");
  a_luma_blank_bypass: assert property ( // RQ2
    CE && !s_q.r07[7] |=> LUMA_2X_NOW == ($past(s_q.r07[4]) && $past(VBLANK_ACTIVE)))
    else $error("blanking bypass wrong");
  a_contrast_cap: assert property ( // RQ12
    CE |=> LUMA_GAIN == (($past(s_q.r0c) > 8'hcf) ? 8'hcf : $past(s_q.r0c)))
    else $error("contrast not capped");
  a_range_601: assert property ( // RQ13
    CE && !s_q.r0d[6] |=> Y_MAX == 8'heb && C_MAX == 8'hf0 && Y_MIN == 8'h10)
    else $error("601 limits wrong");
  a_hue_secam_off: assert property ( // RQ11
    CE && SECAM_SOURCE |=> HUE_ROTATION == 8'h00) else $error("hue applied to SECAM");
  a_start_held: assert property ( // RQ23
    !(wr_en && wr_addr == vdpo_pkg::VDPO_OFF_AV_LO) |=> $stable(ACTIVE_START_OFFSET))
    else $error("start moved without lower write");
  a_start_applied: assert property ( // RQ24
    wr_en && wr_addr == vdpo_pkg::VDPO_OFF_AV_LO |=>
      ACTIVE_START_OFFSET == {$past(s_q.r11), $past(s_q.sh[1:0])})
    else $error("start not applied");
  a_pin27_irq: assert property ( // RQ20
    CE && !s_q.r0f[1] |=> PIN27_OUT == $past(INTERRUPT_REQUEST_IN))
    else $error("pin 27 not interrupt");
  a_pin23_genlock: assert property ( // RQ18
    CE && s_q.r0f[3] |=> PIN23_OUT == $past(GENLOCK_SERIAL_OUT))
    else $error("pin 23 not genlock");
  a_peak_top: assert property ( // RQ7
    CE && s_q.r08[3:2] == 2'h3 |=> PEAK_GAIN_HALVES == 3'h4) else $error("peak gain wrong");

endmodule: vdpo_regs

// *** vdpo_tb.sv ***
// Purpose: Self-checking bench for the picture output register bank.
// Assumes: Registers are reached only over the two-wire port.
// Notes: Driver queues expectations; a watcher compares each result.
`timescale 1ns/1ps
module testbench;
  logic clk = 0, reset_n = 0, scl = 1, sda_m = 1, vbl = 0, secam = 0, wide = 0, gsel = 0;
  logic ce = 1; // Clock enable to the block
  logic [8:0] c = '0; // Candidate pin sources
  logic sda_o, sda_oe, l2x, rawh, ped, trap, cpa, cpo, twos, emb, disc, p23, p24, p27;
  logic [3:0] dly;
  logic [2:0] peak, notch;
  logic [17:0] blk;
  logic [7:0] cg, hue, lg, ymin, ymax, cmin, cmax;
  logic [1:0] dps;
  logic [9:0] avs;
  wire sda_w = sda_m & ~sda_oe; // Wired-AND bus level
  logic [17:0] q[$]; // Expected results
  logic [17:0] obs;
  event got;
  int bad_count = 0, n_compared = 0, cyc = 0;
  logic [31:0] seed = 32'h97638d74;
  logic [7:0] offs[10] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11};
  logic [7:0] dfl[10] = '{8'h60, 8'h00, 8'h80, 8'h80, 8'h00, 8'h80, 8'h47, 8'h00, 8'h08, 8'h00};
  logic [7:0] msk[10] = '{8'hff, 8'h4f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h60, 8'h5e, 8'hff};
  logic [7:0] pcfg[6] = '{8'h08, 8'h40, 8'h00, 8'h04, 8'h14, 8'h02};

  vdpo_regs u_vdpo_regs (.CLK(clk), .RESET_N(reset_n), .CE(ce), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .VBLANK_ACTIVE(vbl), .SECAM_SOURCE(secam),
    .WIDE_CHROMA_FILTER_BIT(wide), .FIELD_INDICATOR(c[0]), .GENLOCK_SERIAL_OUT(c[1]),
    .VSYNC_IN(c[2]), .PAL_LINE_INDICATOR(c[3]), .VERT_LOCKED(c[4]), .HORIZ_LOCKED(c[5]),
    .INTERRUPT_REQUEST_IN(c[6]), .GENERAL_PURPOSE_LEVEL(c[7]), .VERTICAL_BLANK_FLAG(c[8]),
    .VERTICAL_BLANK_FLAG_GENERAL_PURPOSE_LEVEL_SELECT(gsel), .LUMA_2X_NOW(l2x), .RAW_HEADER_DUMMY(rawh),
    .PEDESTAL_PRESENT(ped), .LUMA_DELAY(dly), .LUMA_TRAP_SELECT(trap),
    .PEAK_GAIN_HALVES(peak), .CP_DETECT_AUTO(cpa), .CP_DETECT_FORCE_ON(cpo),
    .BLACK_LEVEL_Q8(blk), .CHROMA_GAIN(cg), .HUE_ROTATION(hue), .LUMA_GAIN(lg),
    .Y_MIN(ymin), .Y_MAX(ymax), .C_MIN(cmin), .C_MAX(cmax), .CHROMA_TWOS_COMP(twos),
    .DATAPATH_SOURCE(dps), .EMBEDDED_SYNC(emb), .DISCRETE_SYNC(disc), .NOTCH_SELECT(notch),
    .PIN23_OUT(p23), .PIN24_OUT(p24), .PIN27_OUT(p27), .ACTIVE_START_OFFSET(avs));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Watcher: oldest note against each observed result
  always @(got) compare(obs, q.pop_front());

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction: xs

  task automatic compare(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask: compare

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask: tally_and_finish

  // Note an expectation and hand the result to the watcher
  task automatic chk(input logic [17:0] v, input logic [17:0] e);
    q.push_back(e);
    obs = v;
    ->got;
    tick(1);
  endtask: chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask: tick

  // One bus phase; 6 clocks keeps above the 4-clock minimum
  task automatic drv(input logic k, input logic d);
    scl = k;
    sda_m = d;
    tick(6);
  endtask: drv

  task automatic put(input logic b);
    drv(0, b);
    drv(1, b);
    drv(0, b);
  endtask: put

  task automatic get(output logic b);
    drv(0, 1);
    drv(1, 1);
    b = sda_w;
    drv(0, 1);
  endtask: get

  task automatic strt;
    drv(0, 1);
    drv(1, 1);
    drv(1, 0);
    drv(0, 0);
  endtask: strt

  task automatic stp;
    drv(0, 0);
    drv(1, 0);
    drv(1, 1);
  endtask: stp

  task automatic tx(input logic [7:0] v);
    logic ack;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(ack);
  endtask: tx

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strt();
    tx({vdpo_pkg::VDPO_DEV_ADDR, 1'b0});
    tx(a);
    tx(d);
    stp();
  endtask: wr

  // Read one register; master NACKs the single byte
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    strt();
    tx({vdpo_pkg::VDPO_DEV_ADDR, 1'b0});
    tx(a);
    strt();
    tx({vdpo_pkg::VDPO_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stp();
  endtask: rd

  // Main sequence
  initial begin
    logic [7:0] v, w;
    logic [1:0] kk;
    int bl;
    tick(20);
    reset_n = 1;
    tick(4);
    chk(blk, 18'h01000);
    // Defaults, then random write and readback
    for (int i = 0; i < 10; i++) begin
      rd(offs[i], v);
      chk(v, dfl[i]);
      seed = xs(seed);
      w = seed[7:0];
      if (i == 5) w[7] = 1'b0;
      if (i == 6) w[2:0] = {3{w[0]}};
      if (i == 8) w[0] = 1'b0;
      wr(offs[i], w);
      rd(offs[i], v);
      chk(v, w & msk[i]);
    end
    wr(8'h07, 8'h9b);
    chk(l2x, 1);
    chk(dly, 4'hb);
    chk(rawh, 0);
    chk(ped, 1);
    wr(8'h07, 8'h70);
    chk(rawh, 1);
    chk(ped, 0);
    for (int k = 0; k < 2; k++) begin
      vbl = k[0];
      tick(3);
      chk(l2x, k);
    end
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      wr(8'h08, {2'b01, 2'b00, kk, ~kk});
      chk(trap, 1);
      chk(peak, (k == 3) ? 4 : k);
      chk(cpa, k > 1);
      chk(cpo, k == 0);
    end
    wr(8'h09, 8'h90);
    wr(8'h0c, 8'hcf);
    bl = 4096 + 256 * 16 + 219 * (128 - 207);
    chk(lg, 8'hcf);
    chk(blk, bl[17:0]);
    wr(8'h0a, 8'h00);
    chk(cg, 0);
    wr(8'h0b, 8'h81);
    chk(hue, 8'h81);
    secam = 1;
    tick(3);
    chk(hue, 0);
    // Frozen block ignores the source change until enabled again
    ce = 0;
    secam = 0;
    tick(3);
    chk(hue, 0);
    ce = 1;
    tick(3);
    chk(hue, 8'h81);
    for (int j = 0; j < 2; j++) begin
      v = j ? 8'h57 : 8'h28;
      wr(8'h0d, v);
      chk(ymin, v[6] ? 8'h01 : 8'h10);
      chk(ymax, v[6] ? 8'hfe : 8'heb);
      chk(cmax, v[6] ? 8'hfe : 8'hf0);
      chk(cmin, v[6] ? 8'h01 : 8'h10);
      chk(twos, v[5]);
      chk(dps, v[4:3]);
      chk(emb, v[2:0] == 3'h7);
      chk(disc, v[2:0] == 3'h0);
    end
    wide = 1;
    wr(8'h0e, 8'h40);
    chk(notch, 3'h6);
    for (int k = 0; k < 6; k++) begin
      v = pcfg[k];
      wr(8'h0f, v);
      repeat (3) begin
        seed = xs(seed);
        {c, gsel} = seed[9:0];
        tick(3);
        chk(p23, v[3] ? c[1] : (v[6] ? c[4] : c[0]));
        chk(p24, v[2] ? (v[4] ? c[5] : c[3]) : c[2]);
        chk(p27, v[1] ? (gsel ? c[8] : c[7]) : c[6]);
      end
    end
    wr(8'h11, 8'h80);
    chk(avs, 10'h000);
    wr(8'h12, 8'h03);
    chk(avs, 10'h203);
    tally_and_finish();
  end
endmodule: testbench
